// ==== core/checker_pkg.sv ====
// shared constants and types for the bit and block error rate checker
package checker_pkg;
   localparam int unsigned CLK_NS      = 10;
   localparam int unsigned PRESENT_NS  = 10000;
   localparam int unsigned PRESENT_CYC = (PRESENT_NS + CLK_NS - 1) / CLK_NS;
   localparam int unsigned TGEN_HALF   = 8;
   localparam int unsigned PRBS_N      = 9;
   localparam int unsigned RUN_LEN     = 32;
   localparam int unsigned MAX_LOOPS   = 3;
   localparam logic [8:0]  PRBS_SEED   = 9'h1ff;
   localparam logic [15:0] CRC_POLY    = 16'h1021;
   localparam logic [31:0] CNT_MAX     = 32'hffffffff;
   // register byte addresses
   localparam logic [7:0]  A_CTRL      = 8'h00;
   localparam logic [7:0]  A_STAT      = 8'h04;
   localparam logic [7:0]  A_BLIM      = 8'h08;
   localparam logic [7:0]  A_ELIM      = 8'h0c;
   localparam logic [7:0]  A_BCNT      = 8'h10;
   localparam logic [7:0]  A_ECNT      = 8'h14;
   localparam logic [7:0]  A_LOOP      = 8'h18;
   // control fields
   localparam int unsigned C_START     = 0;
   localparam int unsigned C_STOP      = 1;
   localparam int unsigned C_BLOCK     = 2;
   localparam int unsigned C_PIGN      = 3;
   localparam int unsigned C_GATE      = 4;
   localparam int unsigned C_RESYNC    = 5;
   // loop fields: internal select low nibble, external enable high nibble
   localparam int unsigned L_SEL       = 0;
   localparam int unsigned L_OE        = 4;
   // reset values
   localparam logic [31:0] BLIM_RST    = 32'h00000000;
   localparam logic [31:0] ELIM_RST    = 32'h00000000;
   // bit order of link_t is also the order of the loop nibbles
   typedef struct packed {
      logic clk;
      logic data;
      logic gate;
      logic resync;
   } link_t;
   typedef enum logic [1:0] {CAUSE_NONE, CAUSE_DATA, CAUSE_ERR,
                             CAUSE_USER} cause_t;
   typedef enum logic [1:0] {ST_IDLE, ST_FILL, ST_RUN} meas_t;
endpackage

// ==== core/bit_block_error_rate_checker.sv ====
// bit and block error rate checker with self-test pattern generator
//
// Summary of operation
// RULE1: restart input holds counts and restarts checking with new data sequence.
// RULE2: each restart returns reference generator to its sequence start.
// RULE3: source must send restart per signal start if length not whole periods.
// RULE4: bit mode skips bits clocked while data gate is low.
// RULE5: block mode checksums only gated bits of each block.
// RULE6: pattern ignore drops runs of 32 or more identical bits.
// RULE7: the equal bit preceding such a run is dropped too.
// RULE8: checked and error counters are 32 bits wide.
// RULE9: manual stop accepted anytime, last counts kept.
// RULE10: stop when count limit or error limit reached, first wins.
// RULE11: stop cause reported: data limit, error limit or user.
// RULE12: continuous mode needs only clock and data, gate and restart unused.
// RULE13: reference degree n repeats every 2^n-1 bits.
// RULE14: error ratio near one half means a failed measurement.
// RULE15: self-test feeds selected checker inputs from generator internally.
// RULE16: every checker input has a matching generator output.
// RULE17: at most three external loop outputs enabled at once.
// RULE18: reference first filled from data, then feedback, then compared.
// RULE19: checksum cleared at block data start, CCITT 16 polynomial.
// RULE20: block error counted when checksums differ.
// RULE21: measurement stops when checked counter would overflow.
// RULE22: status shows clock present, data present and sync.
//
// Our own choices: strobed register access and the placing of the registers.
`timescale 1ns/1ns
module bit_block_error_rate_checker (
   input  wire logic        clk_sys_in,       // system clock
   input  wire logic        rst_n_in,         // async reset, active low
   input  wire logic [7:0]  addr_in,          // register byte address
   input  wire logic [31:0] wdata_in,         // write data
   input  wire logic        wr_in,            // write strobe
   input  wire logic        rd_in,            // read strobe
   output logic      [31:0] rdata_out,        // read data, cycle after rd
   input  wire logic        checked_clock_in, // returned bit clock
   input  wire logic        checked_data_in,  // returned data
   input  wire logic        bit_gate_in,      // data enable
   input  wire logic        resync_strobe_in, // restart
   output logic             loop_clock_out,   // generator clock
   output logic             loop_data_out,    // generator data
   output logic             loop_gate_out,    // generator enable
   output logic             loop_resync_out   // generator restart
);
   localparam int unsigned DL = checker_pkg::RUN_LEN + 1;

   function automatic logic prbs_fb(input logic [8:0] s);
      return s[8] ^ s[4]; // x^9 + x^5 + 1
   endfunction

   function automatic logic [15:0] crc_step(input logic [15:0] c,
                                            input logic d);
      return {c[14:0], 1'b0} ^ ((c[15] ^ d) ? checker_pkg::CRC_POLY : 16'h0);
   endfunction

   checker_pkg::link_t  s1_q, s1_d, s2_q, s3_q, lo_q, lo_d;
   checker_pkg::meas_t  st_q, st_d;
   checker_pkg::cause_t cause_q, cause_d;
   logic [3:0]  sel_q, sel_d, oe_q, oe_d, div_q, div_d, fill_q, fill_d;
   logic [3:0]  pins_v, gen_v;
   logic        tclk_q, tclk_d, tres_q, tres_d, run_q, run_d;
   logic        sync_q, sync_d, rp_q, rp_d, gp_q, gp_d, rxon_q, rxon_d;
   logic        blk_q, blk_d, pi_q, pi_d, gu_q, gu_d, ru_q, ru_d;
   logic [8:0]  tprbs_q, tprbs_d, ref_q, ref_d, refc;
   logic [9:0]  cto_q, cto_d, dto_q, dto_d;
   logic [31:0] bcnt_q, bcnt_d, ecnt_q, ecnt_d, blim_q, blim_d;
   logic [31:0] elim_q, elim_d, rdata_q, rdata_d;
   logic [DL-1:0] dv_q, dv_d, de_q, de_d, dn_q, dn_d, dx_q, dx_d;
   logic [5:0]  rl_q, rl_d;
   logic [15:0] crc_q, crc_d, crx_q, crx_d;
   logic [4:0]  rxn_q, rxn_d;
   logic        cedge, gated, dat, expb, errb, ci, ce, clk_ok, dat_ok;

   assign pins_v = {checked_clock_in, checked_data_in, bit_gate_in,
                    resync_strobe_in};
   assign gen_v  = {tclk_q, tprbs_q[0], 1'b1, tres_q}; // RULE16
   assign cedge  = s2_q.clk & ~s3_q.clk;
   assign dat    = s2_q.data;
   assign gated  = ~gu_q | s2_q.gate; // RULE4 RULE12
   assign refc   = rp_q ? checker_pkg::PRBS_SEED : ref_q;
   assign expb   = prbs_fb(refc);
   assign errb   = dat ^ expb;
   assign clk_ok = cto_q != 10'(checker_pkg::PRESENT_CYC);
   assign dat_ok = dto_q != 10'(checker_pkg::PRESENT_CYC);

   always_comb begin
      s1_d = checker_pkg::link_t'((pins_v & ~sel_q) | (gen_v & sel_q)); // RULE15
      lo_d = checker_pkg::link_t'(gen_v & oe_q);
      {div_d, tclk_d, tprbs_d, tres_d} = {div_q, tclk_q, tprbs_q, tres_q};
      {st_d, cause_d, sel_d, oe_d, fill_d} = {st_q, cause_q, sel_q, oe_q,
                                              fill_q};
      {run_d, sync_d, rp_d, gp_d, rxon_d} = {run_q, sync_q, rp_q, gp_q,
                                             rxon_q};
      {blk_d, pi_d, gu_d, ru_d} = {blk_q, pi_q, gu_q, ru_q};
      {ref_d, bcnt_d, ecnt_d, blim_d, elim_d} = {ref_q, bcnt_q, ecnt_q,
                                                 blim_q, elim_q};
      {dv_d, de_d, dn_d, dx_d, rl_d} = {dv_q, de_q, dn_q, dx_q, rl_q};
      {crc_d, crx_d, rxn_d} = {crc_q, crx_q, rxn_q};
      ci = 1'b0;
      ce = 1'b0;
      rdata_d = '0;
      // generator: data changes on the falling half so it is stable at rise
      div_d = div_q + 4'h1;
      if (div_q == 4'(checker_pkg::TGEN_HALF - 1)) begin
         div_d  = '0;
         tclk_d = ~tclk_q;
         if (tclk_q) begin
            tprbs_d = {tprbs_q[7:0], prbs_fb(tprbs_q)}; // RULE13
            tres_d  = tprbs_q == checker_pkg::PRBS_SEED;
         end
      end
      cto_d = cedge ? '0 : (clk_ok ? cto_q + 10'h1 : cto_q); // RULE22
      dto_d = (s2_q.data != s3_q.data) ? '0 :
              (dat_ok ? dto_q + 10'h1 : dto_q);
      // restart may arrive before the clock edge; hold it for that edge
      if (s2_q.resync && !s3_q.resync && ru_q && run_q)
         rp_d = 1'b1;
      if (run_q && cedge) begin
         rp_d = 1'b0;
         if (rp_q) begin // RULE1 RULE2
            st_d   = checker_pkg::ST_RUN;
            ref_d  = checker_pkg::PRBS_SEED;
            crc_d  = '0;
            rxon_d = 1'b0;
         end
         if (blk_q) begin
            gp_d = s2_q.gate;
            if (s2_q.gate) begin // RULE5
               crc_d  = crc_step((gp_q && !rp_q) ? crc_q : 16'h0, dat); // RULE19
               rxon_d = 1'b0;
            end else if (gp_q) begin
               rxon_d = 1'b1;
               rxn_d  = 5'h1;
               crx_d  = {crx_q[14:0], dat};
            end else if (rxon_q) begin
               crx_d = {crx_q[14:0], dat};
               rxn_d = rxn_q + 5'h1;
               if (rxn_q == 5'h0f) begin
                  rxon_d = 1'b0;
                  ci = 1'b1;
                  ce = {crx_q[14:0], dat} != crc_q; // RULE20
               end
            end
         end else if (gated) begin
            if (st_q == checker_pkg::ST_FILL && !rp_q) begin // RULE18
               ref_d  = {ref_q[7:0], dat};
               fill_d = fill_q + 4'h1;
               if (fill_q == 4'(checker_pkg::PRBS_N - 1)) begin
                  st_d   = checker_pkg::ST_RUN;
                  sync_d = 1'b1;
               end
            end else begin
               ref_d = {refc[7:0], expb};
               dv_d  = {dv_q[DL-2:0], dat};
               de_d  = {de_q[DL-2:0], errb};
               dn_d  = {dn_q[DL-2:0], 1'b1};
               dx_d  = {dx_q[DL-2:0], 1'b0};
               rl_d  = (dn_q[0] && dv_q[0] == dat) ?
                       ((rl_q == 6'(checker_pkg::RUN_LEN)) ? rl_q :
                        rl_q + 6'h1) : 6'h0;
               // the run counter counts repeats, so the first bit of
               // a run is the equal bit just before it
               if (pi_q && rl_d == 6'(checker_pkg::RUN_LEN))
                  dx_d = '1; // RULE6 RULE7
               if (pi_q) begin
                  ci = dn_q[DL-1] & ~dx_q[DL-1];
                  ce = ci & de_q[DL-1];
               end else begin
                  ci = 1'b1;
                  ce = errb;
               end
            end
         end
         if (ci) begin
            bcnt_d = bcnt_q + 32'h1; // RULE8
            if (ce)
               ecnt_d = ecnt_q + 32'h1;
            if ((blim_q != '0 && bcnt_d == blim_q) ||
                bcnt_d == checker_pkg::CNT_MAX) begin // RULE10 RULE21
               run_d   = 1'b0;
               st_d    = checker_pkg::ST_IDLE;
               cause_d = checker_pkg::CAUSE_DATA; // RULE11
            end else if (ce && elim_q != '0 && ecnt_d == elim_q) begin
               run_d   = 1'b0;
               st_d    = checker_pkg::ST_IDLE;
               cause_d = checker_pkg::CAUSE_ERR;
            end
         end
      end
      if (wr_in) begin
         unique case (addr_in)
            checker_pkg::A_CTRL: begin
               blk_d = wdata_in[checker_pkg::C_BLOCK];
               pi_d  = wdata_in[checker_pkg::C_PIGN];
               gu_d  = wdata_in[checker_pkg::C_GATE];
               ru_d  = wdata_in[checker_pkg::C_RESYNC];
               if (wdata_in[checker_pkg::C_START]) begin
                  {bcnt_d, ecnt_d} = '0;
                  {dn_d, dx_d, rl_d, fill_d, crc_d} = '0;
                  {rxon_d, gp_d, rp_d, sync_d} = '0;
                  run_d   = 1'b1;
                  cause_d = checker_pkg::CAUSE_NONE;
                  st_d    = wdata_in[checker_pkg::C_BLOCK] ?
                            checker_pkg::ST_RUN : checker_pkg::ST_FILL;
               end else if (wdata_in[checker_pkg::C_STOP] && run_q) begin
                  run_d   = 1'b0; // RULE9
                  st_d    = checker_pkg::ST_IDLE;
                  cause_d = checker_pkg::CAUSE_USER;
               end
            end
            checker_pkg::A_BLIM: blim_d = wdata_in;
            checker_pkg::A_ELIM: elim_d = wdata_in;
            checker_pkg::A_LOOP: begin
               sel_d = wdata_in[checker_pkg::L_SEL +: 4];
               // an enable set wider than allowed is refused whole
               if ($countones(wdata_in[checker_pkg::L_OE +: 4]) <=
                   checker_pkg::MAX_LOOPS)
                  oe_d = wdata_in[checker_pkg::L_OE +: 4]; // RULE17
            end
            default: ;
         endcase
      end
      if (rd_in) begin
         unique case (addr_in)
            checker_pkg::A_CTRL: rdata_d = {26'h0, ru_q, gu_q, pi_q, blk_q,
                                            2'h0};
            checker_pkg::A_STAT: rdata_d = {26'h0, cause_q, sync_q, dat_ok,
                                            clk_ok, run_q};
            checker_pkg::A_BLIM: rdata_d = blim_q;
            checker_pkg::A_ELIM: rdata_d = elim_q;
            checker_pkg::A_BCNT: rdata_d = bcnt_q;
            checker_pkg::A_ECNT: rdata_d = ecnt_q;
            checker_pkg::A_LOOP: rdata_d = {24'h0, oe_q, sel_q};
            default:             rdata_d = '0;
         endcase
      end
   end

   always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         {s1_q, s2_q, s3_q, lo_q} <= '0;
         {div_q, tclk_q, tres_q} <= '0;
         tprbs_q <= checker_pkg::PRBS_SEED;
         {sel_q, oe_q, fill_q, run_q, sync_q, rp_q, gp_q, rxon_q} <= '0;
         {blk_q, pi_q, gu_q, ru_q} <= '0;
         st_q    <= checker_pkg::ST_IDLE;
         cause_q <= checker_pkg::CAUSE_NONE;
         ref_q   <= '0;
         {cto_q, dto_q} <= {10'(checker_pkg::PRESENT_CYC),
                            10'(checker_pkg::PRESENT_CYC)};
         {bcnt_q, ecnt_q, rdata_q} <= '0;
         blim_q  <= checker_pkg::BLIM_RST;
         elim_q  <= checker_pkg::ELIM_RST;
         {dv_q, de_q, dn_q, dx_q, rl_q} <= '0;
         {crc_q, crx_q, rxn_q} <= '0;
      end else begin
         s1_q <= s1_d;
         s2_q <= s1_q;
         s3_q <= s2_q;
         lo_q <= lo_d;
         {div_q, tclk_q, tprbs_q, tres_q} <= {div_d, tclk_d, tprbs_d, tres_d};
         {sel_q, oe_q, fill_q, st_q, cause_q} <= {sel_d, oe_d, fill_d, st_d,
                                                  cause_d};
         {run_q, sync_q, rp_q, gp_q, rxon_q} <= {run_d, sync_d, rp_d, gp_d,
                                                 rxon_d};
         {blk_q, pi_q, gu_q, ru_q} <= {blk_d, pi_d, gu_d, ru_d};
         {ref_q, cto_q, dto_q} <= {ref_d, cto_d, dto_d};
         {bcnt_q, ecnt_q, blim_q, elim_q} <= {bcnt_d, ecnt_d, blim_d, elim_d};
         {dv_q, de_q, dn_q, dx_q, rl_q} <= {dv_d, de_d, dn_d, dx_d, rl_d};
         {crc_q, crx_q, rxn_q, rdata_q} <= {crc_d, crx_d, rxn_d, rdata_d};
      end
   end

   assign rdata_out       = rdata_q;
   assign loop_clock_out  = lo_q.clk;
   assign loop_data_out   = lo_q.data;
   assign loop_gate_out   = lo_q.gate;
   assign loop_resync_out = lo_q.resync;

   restart_seed_a: assert property (@(posedge clk_sys_in) // RULE2
      disable iff (!rst_n_in) run_q && cedge && rp_q && !blk_q && gated
      && !wr_in |=> ref_q == {checker_pkg::PRBS_SEED[7:0],
                              prbs_fb(checker_pkg::PRBS_SEED)})
      else $error("reference not restarted from seed");
   restart_keep_a: assert property (@(posedge clk_sys_in) // RULE1
      disable iff (!rst_n_in) run_q && cedge && rp_q && !wr_in
      |=> bcnt_q >= $past(bcnt_q) && st_q == checker_pkg::ST_RUN)
      else $error("restart lost counts or state");
   gate_skip_a: assert property (@(posedge clk_sys_in) // RULE4
      disable iff (!rst_n_in) cedge && gu_q && !s2_q.gate && !blk_q
      && !wr_in |=> $stable(bcnt_q) && $stable(ecnt_q))
      else $error("gated bit was counted");
   stop_hold_a: assert property (@(posedge clk_sys_in) // RULE9
      disable iff (!rst_n_in) !run_q && !wr_in
      |=> $stable(bcnt_q) && $stable(ecnt_q))
      else $error("counts moved while stopped");
   limit_stop_a: assert property (@(posedge clk_sys_in) // RULE10
      disable iff (!rst_n_in) run_q && blim_q != '0
      |-> bcnt_q != blim_q)
      else $error("running past the count limit");
   stop_cause_a: assert property (@(posedge clk_sys_in) // RULE11
      disable iff (!rst_n_in) $fell(run_q)
      |-> cause_q != checker_pkg::CAUSE_NONE)
      else $error("stop without cause");
   no_wrap_a: assert property (@(posedge clk_sys_in) // RULE21
      disable iff (!rst_n_in) run_q |-> bcnt_q != checker_pkg::CNT_MAX)
      else $error("checked counter at maximum while running");
   loop_count_a: assert property (@(posedge clk_sys_in) // RULE17
      disable iff (!rst_n_in) $countones(oe_q) <= checker_pkg::MAX_LOOPS)
      else $error("too many loop outputs enabled");
   fill_done_a: assert property (@(posedge clk_sys_in) // RULE18
      disable iff (!rst_n_in) run_q && cedge && gated && !blk_q && !rp_q
      && !wr_in && st_q == checker_pkg::ST_FILL
      && fill_q == 4'(checker_pkg::PRBS_N - 1)
      |=> st_q == checker_pkg::ST_RUN && sync_q)
      else $error("fill did not switch to feedback");
   crc_clear_a: assert property (@(posedge clk_sys_in) // RULE19
      disable iff (!rst_n_in) run_q && cedge && blk_q && !gp_q
      && s2_q.gate && !wr_in |=> crc_q == crc_step(16'h0, $past(dat)))
      else $error("checksum not cleared at block start");
endmodule

// ==== tb/bit_source_model.sv ====
// model of the device under test returning clock, data and enable
`timescale 1ns/1ns
module bit_source_model (
   output logic clk_out,   // returned bit clock
   output logic data_out,  // returned data
   output logic gate_out,  // data enable
   output logic resync_out // restart strobe
);
   logic [8:0] prbs_q;
   initial begin
      clk_out = 1'b0;
      data_out = 1'b0;
      gate_out = 1'b0;
      resync_out = 1'b0;
      prbs_q = 9'h1ff;
   end
   // lines settle half a bit before the rising clock edge
   task automatic put_bit(input logic d, input logic g);
      data_out = d;
      gate_out = g;
      #80 clk_out = 1'b1;
      #80 clk_out = 1'b0;
      resync_out = 1'b0;
   endtask
   // clock stands still between frames; data flips so stale bits fail
   task automatic idle();
      data_out = ~data_out;
      gate_out = 1'b0;
      #160;
   endtask
   // prbs stream of n bits; every ne-th bit flipped, gap masks 2 bits of 8
   task automatic send_prbs(input int n, input bit rst, input int ne,
                            input bit gap);
      logic b;
      logic g;
      if (rst) begin
         prbs_q = 9'h1ff;
         resync_out = 1'b1;
      end
      for (int i = 0; i < n; i++) begin
         g = !(gap && (i % 8 < 2));
         b = prbs_q[8] ^ prbs_q[4];
         if (g) prbs_q = {prbs_q[7:0], b};
         else b = ~data_out;
         if (ne > 0 && i % ne == ne - 1) b = ~b;
         put_bit(b, g);
      end
      idle();
   endtask
   // stuck run repeating the last bit sent; reference keeps stepping so
   // the stream after the run is aligned again
   task automatic send_run(input int n);
      logic v;
      v = ~data_out;
      for (int i = 0; i < n; i++) begin
         prbs_q = {prbs_q[7:0], prbs_q[8] ^ prbs_q[4]};
         put_bit(v, 1'b1);
      end
      idle();
   endtask
   // gated payload then 16 checksum bits, msb first
   task automatic send_block(input logic [31:0] p, input logic [15:0] c);
      for (int i = 31; i >= 0; i--) put_bit(p[i], 1'b1);
      for (int i = 15; i >= 0; i--) put_bit(c[i], 1'b0);
      idle();
   endtask
endmodule

// ==== tb/tb_top.sv ====
// bench for the error rate checker: bus scenarios and returned link
`timescale 1ns/1ns
module tb_top;
   localparam logic [31:0] GO = 32'h1;
   localparam logic [31:0] HALT = 32'h2;
   localparam logic [31:0] CD = 32'(checker_pkg::CAUSE_DATA);
   localparam logic [31:0] CE = 32'(checker_pkg::CAUSE_ERR);
   localparam logic [31:0] CU = 32'(checker_pkg::CAUSE_USER);
   logic        clk_sys_in;
   logic        rst_n_in;
   logic [7:0]  addr_in;
   logic [31:0] wdata_in;
   logic        wr_in;
   logic        rd_in;
   logic [31:0] rdata_out;
   logic        ck;
   logic        dt;
   logic        gt;
   logic        rs;
   logic        lp_clk;
   logic        lp_gate;
   logic [31:0] rv;
   int          n_fail;
   int          n_compared;
   bit_block_error_rate_checker u_bit_block_error_rate_checker (
      .clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in), .addr_in(addr_in),
      .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
      .rdata_out(rdata_out), .checked_clock_in(ck),
      .checked_data_in(dt), .bit_gate_in(gt), .resync_strobe_in(rs),
      .loop_clock_out(lp_clk), .loop_data_out(), .loop_gate_out(lp_gate),
      .loop_resync_out());
   bit_source_model u_bit_source_model (
      .clk_out(ck), .data_out(dt), .gate_out(gt), .resync_out(rs));
   always #5 clk_sys_in = ~clk_sys_in;
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         n_fail++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_sys_in);
      addr_in <= a;
      wdata_in <= d;
      wr_in <= 1'b1;
      @(posedge clk_sys_in);
      wr_in <= 1'b0;
   endtask
   // read data stand only in the cycle after the strobe
   task automatic rd(input logic [7:0] a);
      @(posedge clk_sys_in);
      addr_in <= a;
      rd_in <= 1'b1;
      @(posedge clk_sys_in);
      rd_in <= 1'b0;
      @(negedge clk_sys_in);
      rv = rdata_out;
   endtask
   task automatic rc(input logic [7:0] a, input logic [31:0] e);
      rd(a);
      chk(rv, e);
   endtask
   task automatic stat(input logic [31:0] cause);
      rd(checker_pkg::A_STAT);
      chk(32'(rv[0]), 32'h0);
      chk(32'(rv[5:4]), cause);
   endtask
   task automatic prbs(input int n, input bit r, input int ne, input bit g);
      u_bit_source_model.send_prbs(n, r, ne, g);
      repeat (20) @(posedge clk_sys_in);
   endtask
   function automatic logic [15:0] crc(input logic [31:0] d);
      logic [15:0] c;
      c = 16'h0000;
      for (int i = 31; i >= 0; i--)
         c = {c[14:0], 1'b0} ^
             ((c[15] ^ d[i]) ? checker_pkg::CRC_POLY : 16'h0000);
      return c;
   endfunction
   task automatic t_reset();
      rc(checker_pkg::A_BLIM, checker_pkg::BLIM_RST);
      rc(checker_pkg::A_ELIM, checker_pkg::ELIM_RST);
      rc(checker_pkg::A_BCNT, 32'h0);
      rc(checker_pkg::A_ECNT, 32'h0);
      wr(8'h40, 32'hffffffff);
      rc(8'h40, 32'h0);
      rc(checker_pkg::A_LOOP, 32'h0);
      stat(32'h0);
      $display("reset values done");
   endtask
   task automatic t_limits();
      wr(checker_pkg::A_BLIM, 32'd100);
      wr(checker_pkg::A_CTRL, GO);
      prbs(130, 0, 0, 0);
      rc(checker_pkg::A_BCNT, 32'd100);
      rc(checker_pkg::A_ECNT, 32'd0);
      stat(CD);
      chk(32'(rv[3:1]), 32'h7);
      wr(checker_pkg::A_BLIM, 32'h0);
      wr(checker_pkg::A_ELIM, 32'd3);
      wr(checker_pkg::A_CTRL, GO);
      prbs(200, 0, 10, 0);
      rc(checker_pkg::A_ECNT, 32'd3);
      rc(checker_pkg::A_BCNT, 32'd21);
      stat(CE);
      wr(checker_pkg::A_ELIM, 32'h0);
      $display("limit stops done");
   endtask
   task automatic t_user_stop();
      wr(checker_pkg::A_CTRL, GO);
      prbs(60, 0, 0, 0);
      wr(checker_pkg::A_CTRL, HALT);
      rc(checker_pkg::A_BCNT, 32'd51);
      prbs(40, 0, 7, 0);
      rc(checker_pkg::A_BCNT, 32'd51);
      rc(checker_pkg::A_ECNT, 32'd0);
      stat(CU);
      $display("user stop done");
   endtask
   task automatic t_gate();
      int e;
      e = -9;
      for (int i = 0; i < 100; i++) if (i % 8 >= 2) e++;
      wr(checker_pkg::A_CTRL, GO | 32'h10);
      prbs(100, 0, 0, 1);
      wr(checker_pkg::A_CTRL, HALT);
      rc(checker_pkg::A_ECNT, 32'd0);
      rc(checker_pkg::A_BCNT, 32'(e));
      $display("gate done");
   endtask
   // 40 stuck bits plus the equal bit before them must vanish; the last
   // 33 bits before the stop are never counted under pattern ignore
   task automatic t_ignore();
      wr(checker_pkg::A_CTRL, GO | 32'h08);
      prbs(50, 0, 0, 0);
      u_bit_source_model.send_run(40);
      prbs(60, 0, 0, 0);
      wr(checker_pkg::A_CTRL, HALT);
      rc(checker_pkg::A_ECNT, 32'd0);
      rd(checker_pkg::A_BCNT);
      chk(32'(rv <= 32'd67), 32'h1);
      chk(32'(rv >= 32'd58), 32'h1);
      $display("pattern ignore done");
   endtask
   // every frame restarts the source from the seed
   task automatic t_restart();
      wr(checker_pkg::A_BLIM, 32'd150);
      wr(checker_pkg::A_CTRL, GO | 32'h30);
      repeat (3) prbs(100, 1, 0, 0);
      rc(checker_pkg::A_ECNT, 32'd0);
      chk(32'(rv < 32'd75), 32'h1);
      rc(checker_pkg::A_BCNT, 32'd150);
      stat(CD);
      wr(checker_pkg::A_BLIM, 32'h0);
      $display("restart done");
   endtask
   // bad block between good ones: checksum must clear per block
   task automatic t_block();
      wr(checker_pkg::A_CTRL, GO | 32'h04);
      u_bit_source_model.send_block(32'hc3a5_0f91, crc(32'hc3a5_0f91));
      u_bit_source_model.send_block(32'h1234_5678, ~crc(32'h1234_5678));
      u_bit_source_model.send_block(32'hffff_0001, crc(32'hffff_0001));
      repeat (20) @(posedge clk_sys_in);
      wr(checker_pkg::A_CTRL, HALT);
      rc(checker_pkg::A_BCNT, 32'd3);
      rc(checker_pkg::A_ECNT, 32'd1);
      $display("block done");
   endtask
   task automatic t_loop();
      wr(checker_pkg::A_LOOP, 32'hf0);
      rc(checker_pkg::A_LOOP, 32'h00);
      wr(checker_pkg::A_LOOP, 32'h7f);
      rc(checker_pkg::A_LOOP, 32'h7f);
      chk(32'({lp_clk, lp_gate}), 32'h1);
      wr(checker_pkg::A_BLIM, 32'd200);
      wr(checker_pkg::A_CTRL, GO);
      for (int i = 0; i < 3000; i++) begin
         rd(checker_pkg::A_STAT);
         if (rv[0] === 1'b0) break;
      end
      stat(CD);
      rc(checker_pkg::A_BCNT, 32'd200);
      rc(checker_pkg::A_ECNT, 32'd0);
      wr(checker_pkg::A_LOOP, 32'h0);
      $display("self test done");
   endtask
   task automatic wrap_up();
      $display("compared %0d mismatched %0d", n_compared, n_fail);
      if (n_fail == 0 && n_compared > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   initial begin
      n_fail = 0;
      n_compared = 0;
      clk_sys_in = 1'b0;
      rst_n_in = 1'b0;
      addr_in = 8'h00;
      wdata_in = 32'h0;
      wr_in = 1'b0;
      rd_in = 1'b0;
      repeat (10) @(posedge clk_sys_in);
      rst_n_in <= 1'b1;
      t_reset();
      t_limits();
      t_user_stop();
      t_gate();
      t_ignore();
      t_restart();
      t_block();
      t_loop();
      wrap_up();
   end
   // the tests need about 0.22 ms of link traffic
   initial begin
      #1000000;
      n_fail++;
      wrap_up();
   end
endmodule
